// *** rtl/autoneg_partner_ability_status.sv ***
`timescale 1ns/1ps
module autoneg_partner_ability_status
  import autoneg_pkg::*;
#(
  parameter int AW = autoneg_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  // management register port
  input  wire logic [AW-1:0]           reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  // from the arbitration logic, same clock
  input  wire autoneg_pkg::rx_page_t   rx_page,
  input  wire autoneg_pkg::an_state_t  an_state,
  // configuration pins, asynchronous
  input  wire autoneg_pkg::strap_t     strap,
  // to the arbitration logic
  output logic      [15:0]             adv_word,
  output logic                         alt_np_en,
  // interrupt
  output logic                         irq
);
  import autoneg_pkg::*;

  if (AW < ADDR_W) begin : g_bad_aw
    $error("address width too narrow for the register map");
  end

  // ---------------- strap capture ----------------

  strap_t     strap_meta;
  strap_t     strap_sync;
  logic [1:0] strap_cnt;
  logic       strap_done;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= strap;
      strap_sync <= strap_meta;
    end
  end

  // wait until the synchroniser holds pin values, then load once
  wire strap_load = !strap_done && (strap_cnt == STRAP_SYNC_CYC);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt  <= strap_cnt + 2'h1;
      strap_done <= strap_load;
    end
  end

  // ---------------- address decode ----------------

  wire hit_adv   = (reg_addr == AW'(ADV_OFS));
  wire hit_base  = (reg_addr == AW'(LP_BASE_OFS));
  wire hit_exp   = (reg_addr == AW'(EXP_OFS));
  wire hit_next  = (reg_addr == AW'(LP_NEXT_OFS));
  wire hit_cfg   = (reg_addr == AW'(PORT_CFG_OFS));
  wire hit_istat = (reg_addr == AW'(IRQ_STAT_OFS));
  wire hit_imask = (reg_addr == AW'(IRQ_MASK_OFS));

  wire wr_adv   = reg_wr && hit_adv;
  wire wr_cfg   = reg_wr && hit_cfg;
  wire wr_imask = reg_wr && hit_imask;
  wire rd_exp   = reg_rd && hit_exp;
  wire rd_istat = reg_rd && hit_istat;

  // ---------------- advertisement ----------------

  logic [15:0] adv;

  wire [15:0] adv_strap = {adv[15:11], strap_sync.pause, adv[9],
                           strap_sync.ability, adv[4:0]};
  wire [15:0] adv_wr    = (reg_wdata & ADV_WR_MASK) | (adv & ~ADV_WR_MASK);

  // pins win over a write landing in the same cycle, once only
  wire [15:0] next_adv = strap_load ? adv_strap :
                         wr_adv     ? adv_wr    : adv;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      adv <= ADV_RST;
    end else begin
      adv <= next_adv;
    end
  end

  // ---------------- port configuration ----------------

  logic [15:0] cfg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= CFG_RST;
    end else if (wr_cfg) begin
      cfg <= reg_wdata & CFG_WR_MASK;
    end
  end

  wire alt_np = cfg[CFG_ALT_NP_BIT];

  // ---------------- received pages ----------------

  logic [15:0] lp_base;
  logic [15:0] lp_next;

  wire load_base = rx_page.valid && !rx_page.next_page;
  wire load_next = rx_page.valid && rx_page.next_page;

  // base page keeps the code word in place, except bit 12, which is loaded as zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lp_base <= LP_RST;
    end else if (load_base) begin
      lp_base[NP_BIT]            <= rx_page.word[NP_BIT];
      lp_base[ACK_BIT]           <= rx_page.word[ACK_BIT];
      lp_base[RF_BIT]            <= rx_page.word[RF_BIT];
      lp_base[12]                <= 1'b0;
      lp_base[APAUSE_BIT]        <= rx_page.word[APAUSE_BIT];
      lp_base[PAUSE_BIT]         <= rx_page.word[PAUSE_BIT];
      lp_base[T4_BIT:T_BIT]      <= rx_page.word[T4_BIT:T_BIT];
      lp_base[SEL_HI:0]          <= rx_page.word[SEL_HI:0];
    end
  end

  // next pages never disturb the base page
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lp_next <= LP_RST;
    end else if (load_next) begin
      lp_next <= rx_page.word;
    end
  end

  // ---------------- expansion flags ----------------

  logic mr_page_rx_q;
  logic tx_dis_q;

  // edges of the arbitration variables, same clock so no synchroniser
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mr_page_rx_q <= 1'b0;
      tx_dis_q     <= 1'b0;
    end else begin
      mr_page_rx_q <= an_state.mr_page_rx;
      tx_dis_q     <= an_state.transmit_disable;
    end
  end

  wire page_rx_fell = mr_page_rx_q && !an_state.mr_page_rx;
  wire tx_dis_rose  = !tx_dis_q && an_state.transmit_disable;

  wire set_base_page = alt_np && an_state.base_page;
  wire set_pd_fault  = an_state.parallel_fault;
  wire set_page_rx   = rx_page.valid;
  wire clr_page_rx   = rd_exp || (alt_np && (page_rx_fell || tx_dis_rose));

  logic base_page_flag;
  logic pd_fault_flag;
  logic page_rx_flag;

  // a held source re-sets the flag at once, so after a read it shows the live value
  latch_high_flag u_base_page (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .set     (set_base_page),
    .clr     (rd_exp),
    .q       (base_page_flag)
  );

  latch_high_flag u_pd_fault (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .set     (set_pd_fault),
    .clr     (rd_exp),
    .q       (pd_fault_flag)
  );

  latch_high_flag u_page_rx (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .set     (set_page_rx),
    .clr     (clr_page_rx),
    .q       (page_rx_flag)
  );

  logic lp_an_able;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lp_an_able <= 1'b0;
    end else begin
      lp_an_able <= an_state.partner_an_able;
    end
  end

  // the register is read-only, so writes at this address do nothing
  wire [15:0] exp_word = {10'h000,
                          base_page_flag,
                          pd_fault_flag,
                          lp_base[NP_BIT],
                          1'b1,
                          page_rx_flag,
                          lp_an_able};

  // ---------------- interrupts ----------------

  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;

  wire [IRQ_W-1:0] irq_evt = {set_base_page, set_pd_fault, set_page_rx};

  // set wins over the clear of a status read in the same cycle
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~{IRQ_W{rd_istat}}) | irq_evt;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= MASK_RST;
    end else if (wr_imask) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end

  // registered output, so it follows the status by one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ---------------- read path ----------------

  // values are taken before the read-clear lands; unmapped reads return zero
  wire [15:0] rd_mux = hit_adv   ? adv                        :
                       hit_base  ? lp_base                    :
                       hit_exp   ? exp_word                   :
                       hit_next  ? lp_next                    :
                       hit_cfg   ? cfg                        :
                       hit_istat ? {13'h0000, irq_stat}       :
                       hit_imask ? {13'h0000, irq_mask}       :
                                   16'h0000;

  // data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ---------------- outputs to the arbitration logic ----------------

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      adv_word  <= ADV_RST;
      alt_np_en <= 1'b0;
    end else begin
      adv_word  <= next_adv;
      alt_np_en <= alt_np;
    end
  end

endmodule

// *** rtl/autoneg_pkg.sv ***
package autoneg_pkg;

  // register map, word addresses on the management port
  localparam int        ADDR_W        = 5;
  localparam logic [4:0] ADV_OFS      = 5'h04;
  localparam logic [4:0] LP_BASE_OFS  = 5'h05;
  localparam logic [4:0] EXP_OFS      = 5'h06;
  localparam logic [4:0] LP_NEXT_OFS  = 5'h08;
  localparam logic [4:0] PORT_CFG_OFS = 5'h10;
  localparam logic [4:0] IRQ_STAT_OFS = 5'h11;
  localparam logic [4:0] IRQ_MASK_OFS = 5'h12;

  // code word fields (base page and advertisement share the layout)
  localparam int NP_BIT     = 15;
  localparam int ACK_BIT    = 14;
  localparam int RF_BIT     = 13;
  localparam int APAUSE_BIT = 11;
  localparam int PAUSE_BIT  = 10;
  localparam int T4_BIT     = 9;
  localparam int TXFD_BIT   = 8;
  localparam int TX_BIT     = 7;
  localparam int TFD_BIT    = 6;
  localparam int T_BIT      = 5;
  localparam int SEL_HI     = 4;

  // expansion register fields
  localparam int EXP_BASE_PAGE  = 5;
  localparam int EXP_PD_FAULT   = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_NP_ABLE    = 2;
  localparam int EXP_PAGE_RX    = 1;
  localparam int EXP_LP_AN_ABLE = 0;

  // port configuration fields
  localparam int CFG_ALT_NP_BIT = 1;

  // interrupt status and mask fields
  localparam int IRQ_W         = 3;
  localparam int IRQ_PAGE_RX   = 0;
  localparam int IRQ_PD_FAULT  = 1;
  localparam int IRQ_BASE_PAGE = 2;

  // selector codes
  localparam logic [4:0] SEL_IEEE8023 = 5'h01;

  // reset values and write masks
  localparam logic [15:0]      ADV_RST     = {11'h000, SEL_IEEE8023};
  localparam logic [15:0]      ADV_WR_MASK = 16'hbfff;
  localparam logic [15:0]      LP_RST      = 16'h0000;
  localparam logic [15:0]      CFG_RST     = 16'h0000;
  localparam logic [15:0]      CFG_WR_MASK = 16'h0002;
  localparam logic [IRQ_W-1:0] MASK_RST    = 3'h0;

  // cycles the strap synchroniser needs before its output is trusted
  localparam logic [1:0] STRAP_SYNC_CYC = 2'h2;

  // received code word from the arbitration logic
  typedef struct packed {
    logic        valid;
    logic        next_page;
    logic [15:0] word;
  } rx_page_t;

  // arbitration variables, all levels except parallel_fault
  typedef struct packed {
    logic partner_an_able;
    logic parallel_fault;
    logic base_page;
    logic mr_page_rx;
    logic transmit_disable;
  } an_state_t;

  // configuration pins caught after reset
  typedef struct packed {
    logic       pause;
    logic [3:0] ability;
  } strap_t;

endpackage

// *** rtl/latch_high_flag.sv ***
`timescale 1ns/1ps
module latch_high_flag (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // condition that sets the flag
  input  wire logic set,
  // condition that clears the flag
  input  wire logic clr,
  // flag
  output logic      q
);

  // set wins over clear, so an event in the clearing cycle is kept
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule

// *** tb/an_arb_model.sv ***
`timescale 1ns/1ps
module an_arb_model
  import autoneg_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // toward the status block
  output autoneg_pkg::rx_page_t  rx_page,
  output autoneg_pkg::an_state_t an_state
);
  initial begin
    rx_page  = '0;
    an_state = '0;
  end
  // word is inverted once valid drops so a stale copy is never mistaken for data
  task automatic send_page(input logic [15:0] w, input logic np);
    rx_page <= '{valid: 1'b1, next_page: np, word: w};
    @(posedge ref_clk);
    rx_page <= '{valid: 1'b0, next_page: np, word: ~w};
  endtask
  task automatic set_state(input an_state_t s);
    an_state <= s;
  endtask
endmodule

// *** tb/autoneg_partner_ability_status_chk.sv ***
`timescale 1ns/1ps
module autoneg_partner_ability_status_chk
  import autoneg_pkg::*;
#(
  parameter int AW = autoneg_pkg::ADDR_W
) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  // register port
  input wire logic [AW-1:0]          reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  // arbitration side and pins
  input wire autoneg_pkg::rx_page_t  rx_page,
  input wire autoneg_pkg::an_state_t an_state,
  input wire autoneg_pkg::strap_t    strap,
  // outputs
  input wire logic [15:0]            adv_word,
  input wire logic                   alt_np_en,
  input wire logic                   irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire rd_exp = reg_rd && reg_addr == AW'(EXP_OFS);
  wire rd_base = reg_rd && reg_addr == AW'(LP_BASE_OFS);
  // no latch source active, so a read leaves every latched bit low
  wire quiet = !rx_page.valid && !an_state.parallel_fault && !(alt_np_en && an_state.base_page);
  sequence s_base_rd;
    rx_page.valid && !rx_page.next_page ##1 rd_base && !rx_page.valid;
  endsequence
  sequence s_rd_twice;
    rd_exp && quiet ##1 rd_exp;
  endsequence
  sequence s_alt_drop;
    alt_np_en && !rx_page.valid &&
      ($fell(an_state.mr_page_rx) || $rose(an_state.transmit_disable))
    ##1 (alt_np_en && !rx_page.valid)[*2] ##1 rd_exp && !rx_page.valid;
  endsequence
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_exp_const;
    rd_exp |=> reg_rdata[15:6] == 10'h000 && reg_rdata[2];
  endproperty
  a_exp_const: assert property (p_exp_const) else $error("expansion fixed bits");
  property p_base_load;
    s_base_rd |=> reg_rdata == ($past(rx_page.word, 2) & 16'hefff);
  endproperty
  a_base_load: assert property (p_base_load) else $error("base page word");
  property p_page_flag;
    rx_page.valid && !alt_np_en ##1 !rd_exp ##1 rd_exp |=> reg_rdata[1];
  endproperty
  a_page_flag: assert property (p_page_flag) else $error("page flag not set");
  property p_pd_hold;
    an_state.parallel_fault ##1 (!rd_exp)[*3] ##1 rd_exp |=> reg_rdata[4];
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("fault flag lost");
  property p_flags_clr;
    s_rd_twice |=> reg_rdata[5:4] == 2'h0 && !reg_rdata[1];
  endproperty
  a_flags_clr: assert property (p_flags_clr) else $error("flags not cleared");
  property p_alt_clr;
    s_alt_drop |=> !reg_rdata[1];
  endproperty
  a_alt_clr: assert property (p_alt_clr) else $error("page flag kept");
  property p_an_able;
    rd_exp |=> reg_rdata[0] == $past(an_state.partner_an_able, 2);
  endproperty
  a_an_able: assert property (p_an_able) else $error("partner able bit");
endmodule
bind autoneg_partner_ability_status autoneg_partner_ability_status_chk #(.AW(AW)) chk_inst (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_page(rx_page),
  .an_state(an_state), .strap(strap), .adv_word(adv_word), .alt_np_en(alt_np_en), .irq(irq));

// *** tb/test_autoneg_partner_ability_status.sv ***
`timescale 1ns/1ps
module test_autoneg_partner_ability_status;
  import autoneg_pkg::*;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [15:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [15:0]       reg_rdata, adv_word;
  logic              alt_np_en, irq;
  rx_page_t          rx_page;
  an_state_t         an_state;
  strap_t            strap = '{pause: 1'b1, ability: 4'ha};
  int                mismatches = 0;
  int                compares = 0;
  logic [15:0]       pages [6] = '{16'h8001, 16'h4002, 16'h2000, 16'h0c1f, 16'h03e0, 16'h1000};
  always #2.5 ref_clk = ~ref_clk;
  an_arb_model an_arb_model_inst (.ref_clk(ref_clk), .rx_page(rx_page), .an_state(an_state));
  autoneg_partner_ability_status autoneg_partner_ability_status_inst (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_page(rx_page),
    .an_state(an_state), .strap(strap), .adv_word(adv_word), .alt_np_en(alt_np_en),
    .irq(irq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // step off the edge so a following call never re-drives the strobe in this time step
    #1;
  endtask
  // read data is registered, so it is taken just after the edge that took the strobe
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc(5000);
    mismatches++;
    give_verdict();
  end
  initial begin
    cyc(8);
    nrst <= 1'b1;
    cyc(5);
    #1;
    check(adv_word, {5'h00, strap.pause, 1'b0, strap.ability, SEL_IEEE8023});
    rdc(LP_BASE_OFS, 16'h0000);
    rdc(EXP_OFS, 16'h0004);
    $display("reset values done");
    foreach (pages[i]) begin
      an_arb_model_inst.send_page(pages[i], 1'b0);
      rdc(LP_BASE_OFS, pages[i] & 16'hefff);
      rdc(EXP_OFS, {12'h000, pages[i][15], 3'h6});
    end
    check({15'h0000, irq}, 16'h0000);
    an_arb_model_inst.send_page(16'h5555, 1'b1);
    rdc(LP_BASE_OFS, 16'h0000);
    rdc(LP_NEXT_OFS, 16'h5555);
    rdc(EXP_OFS, 16'h0006);
    rdc(EXP_OFS, 16'h0004);
    wr(LP_BASE_OFS, 16'hffff);
    wr(EXP_OFS, 16'hffff);
    rdc(LP_BASE_OFS, 16'h0000);
    rdc(EXP_OFS, 16'h0004);
    rdc(5'h1f, 16'h0000);
    $display("page tests done");
    an_arb_model_inst.set_state(5'b11000);
    cyc(1);
    an_arb_model_inst.set_state(5'b10000);
    cyc(3);
    rdc(EXP_OFS, 16'h0015);
    rdc(EXP_OFS, 16'h0005);
    $display("fault tests done");
    wr(PORT_CFG_OFS, 16'h0002);
    // the option output is registered one edge behind the configuration register
    cyc(1);
    #1;
    check({15'h0000, alt_np_en}, 16'h0001);
    an_arb_model_inst.set_state(5'b10100);
    cyc(1);
    an_arb_model_inst.set_state(5'b10010);
    an_arb_model_inst.send_page(16'h8001, 1'b0);
    an_arb_model_inst.set_state(5'b10000);
    cyc(3);
    rdc(EXP_OFS, 16'h002d);
    an_arb_model_inst.send_page(16'h8001, 1'b0);
    an_arb_model_inst.set_state(5'b10001);
    cyc(3);
    rdc(EXP_OFS, 16'h000d);
    $display("alternate option tests done");
    rdc(IRQ_STAT_OFS, 16'h0007);
    wr(IRQ_MASK_OFS, 16'h0001);
    #1;
    check({15'h0000, irq}, 16'h0000);
    an_arb_model_inst.send_page(16'h0021, 1'b0);
    cyc(1);
    #1;
    check({15'h0000, irq}, 16'h0001);
    rdc(IRQ_STAT_OFS, 16'h0001);
    cyc(1);
    #1;
    check({15'h0000, irq}, 16'h0000);
    $display("interrupt tests done");
    // second reset with other pin values: the advertisement must follow the pins again
    strap <= '{pause: 1'b0, ability: 4'h5};
    nrst  <= 1'b0;
    cyc(2);
    nrst  <= 1'b1;
    cyc(5);
    #1;
    check(adv_word, {5'h00, 1'b0, 1'b0, 4'h5, SEL_IEEE8023});
    rdc(ADV_OFS, {5'h00, 1'b0, 1'b0, 4'h5, SEL_IEEE8023});
    rdc(LP_BASE_OFS, 16'h0000);
    rdc(EXP_OFS, 16'h0005);
    $display("second reset done");
    give_verdict();
  end
endmodule
